// ### psc_pkg.sv
// Shared constants of the port stage configuration and check block
package psc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_CTRL1  = 4'h2;
  localparam logic [3:0] REG_CTRL2  = 4'h3;
  localparam logic [3:0] REG_L1_HI  = 4'h4;
  localparam logic [3:0] REG_L1_LO  = 4'h5;
  localparam logic [3:0] REG_L2_HI  = 4'h6;
  localparam logic [3:0] REG_L2_LO  = 4'h7;
  localparam logic [3:0] REG_CHECK  = 4'h8;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int STAGE_MSB      = 7;
  localparam int STAGE_LSB      = 5;
  localparam int STATUS_PE_BIT  = 0;
  localparam int STATUS_OVL_BIT = 4;

  // ----------------------------------------------------------------
  // Stage select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STAGE_OFF  = 3'h0;
  localparam logic [2:0] STAGE_TRI  = 3'h4;
  localparam logic [2:0] STAGE_LSON = 3'h5;
  localparam logic [2:0] STAGE_HSON = 3'h6;
  localparam logic [2:0] STAGE_PPI  = 3'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h80;
  localparam logic [7:0] RST_CTRL1  = 8'h21;
  localparam logic [7:0] RST_CTRL2  = 8'h21;
  localparam logic [7:0] RST_LED    = 8'h00;
  localparam logic [7:0] RST_CHECK  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int LED_STEP_MS     = 63;
  localparam int LED_STEP_CYCLES = LED_STEP_MS * (CLK_HZ / 1000);
  localparam int DEAD_TIME_NS    = 500;
  localparam int DEAD_CYCLES     = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : psc_pkg

// ### psc_led_if.sv
// Carrier between the register bank and one LED pattern scanner
`timescale 1ns/100ps
`default_nettype none
interface psc_led_if;
  logic [15:0] pattern;
  logic        step;
  logic        led_on;
  modport bank    (output pattern, output step, input led_on);
  modport scanner (input pattern, input step, output led_on);
endinterface : psc_led_if
`default_nettype wire

// ### psc_led_scan.sv
// LED pattern scanner, one bit per step
`timescale 1ns/100ps
`default_nettype none
module psc_led_scan (
  input  wire logic   clk_i,
  input  wire logic   reset_n_i,
  psc_led_if.scanner  led
);
  import psc_pkg::*;

  logic [3:0] idx_r;
  logic       on_r;

  // ----------------------------------------------------------------
  // Scan, bit 15 first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_r <= 4'hf;
      on_r  <= 1'b0;
    end else if (led.step) begin
      on_r  <= led.pattern[idx_r];
      idx_r <= idx_r - 4'h1;
    end
  end

  assign led.led_on = on_r;

  led_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    led.step |=> led.led_on == $past(led.pattern[idx_r]))
    else $error("led output does not follow pattern bit");

endmodule : psc_led_scan
`default_nettype wire

// ### psc_port_stage.sv
// Port stage configuration, transition check, LED patterns and parity
`timescale 1ns/100ps
`default_nettype none
module psc_port_stage #(
  parameter int LED_STEP_CYC = psc_pkg::LED_STEP_CYCLES,
  parameter int DEAD_CYC     = psc_pkg::DEAD_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_stb_i,
  input  wire logic [3:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_end_i,
  input  wire logic       rd_stb_i,
  input  wire logic [3:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       drv_en_i,
  input  wire logic       tx_i,
  input  wire logic       line_sense_i,
  input  wire logic       line_cutoff_i,
  input  wire logic       supply_en_i,
  input  wire logic       supply_cutoff_i,
  input  wire logic       aux_in_i,
  input  wire logic       fault_i,
  output logic            high_side_switch_o,
  output logic            low_side_switch_o,
  output logic            slow_decay_o,
  output logic            receiver_on_o,
  output logic            rx_o,
  output logic            supply_switch_o,
  output logic            fast_clamp_o,
  output logic            aux_rx_on_o,
  output logic            aux_rx_o,
  output logic            led1_out_o,
  output logic            led1_oe_n_o,
  output logic            led2_out_o,
  output logic            led2_oe_n_o,
  output logic            fault_req_out_o,
  output logic            fault_req_oe_n_o
);
  import psc_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_active(input logic [2:0] code);
    is_active = (code != STAGE_OFF) && (code != STAGE_TRI);
  endfunction : is_active

  function automatic logic is_forbidden(input logic [2:0] cur, input logic [2:0] nxt);
    is_forbidden = is_active(cur) && is_active(nxt) && (cur != nxt);
  endfunction : is_forbidden

  function automatic logic [7:0] reset_of(input int idx);
    case (idx)
      1:       reset_of = RST_CONFIG;
      2:       reset_of = RST_CTRL1;
      3:       reset_of = RST_CTRL2;
      default: reset_of = RST_LED;
    endcase
  endfunction : reset_of

  // ----------------------------------------------------------------
  // Register storage and write staging
  // ----------------------------------------------------------------
  logic [7:0] wreg_r  [1:7];
  logic [7:0] stage_r [1:7];
  logic [7:0] stage_v_r;
  logic       bad_r;
  logic [7:0] status_r;
  logic [7:0] check_r;
  logic [7:0] wreg_nxt [1:7];
  logic [2:0] code;
  logic       commit;

  assign code   = wreg_r[1][STAGE_MSB:STAGE_LSB];
  assign commit = wr_end_i;

  always_comb begin
    for (int i = 1; i < 8; i++) begin
      wreg_nxt[i] = (!bad_r && stage_v_r[i]) ? stage_r[i] : wreg_r[i];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_v_r <= 8'h00;
      bad_r     <= 1'b0;
      for (int i = 1; i < 8; i++) begin
        stage_r[i] <= 8'h00;
      end
    end else if (commit) begin
      stage_v_r <= 8'h00;
      bad_r     <= 1'b0;
    end else if (wr_stb_i && wr_addr_i >= REG_CONFIG && wr_addr_i <= REG_L2_LO) begin
      stage_r[wr_addr_i[2:0]]   <= wr_data_i;
      stage_v_r[wr_addr_i[2:0]] <= 1'b1;
      if (wr_addr_i == REG_CONFIG && is_forbidden(code, wr_data_i[STAGE_MSB:STAGE_LSB])) begin
        bad_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 1; i < 8; i++) begin
        wreg_r[i] <= reset_of(i);
      end
    end else if (commit) begin
      for (int i = 1; i < 8; i++) begin
        wreg_r[i] <= wreg_nxt[i];
      end
    end
  end

  // Status: rejected stage jump and overload, cleared by reading, set wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= RST_STATUS;
    end else begin
      status_r[STATUS_PE_BIT]  <= (commit && bad_r) ||
                                  (status_r[STATUS_PE_BIT] && !(rd_stb_i && rd_addr_i == REG_STATUS));
      status_r[STATUS_OVL_BIT] <= fault_i ||
                                  (status_r[STATUS_OVL_BIT] && !(rd_stb_i && rd_addr_i == REG_STATUS));
    end
  end

  // Check register recomputed at each commit (wr_end_i), not at each staged write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      check_r <= RST_CHECK;
    end else if (commit) begin
      check_r <= {^status_r, ^wreg_nxt[1], ^wreg_nxt[2], ^wreg_nxt[3],
                  ^wreg_nxt[4], ^wreg_nxt[5], ^wreg_nxt[6], ^wreg_nxt[7]};
    end
  end

  // Read port; check register has no write path
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_stb_i) begin
      if (rd_addr_i == REG_STATUS) begin
        rd_data_o <= status_r;
      end else if (rd_addr_i == REG_CHECK) begin
        rd_data_o <= check_r;
      end else if (rd_addr_i <= REG_L2_LO) begin
        rd_data_o <= wreg_r[rd_addr_i[2:0]];
      end else begin
        rd_data_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage with dead time
  // ----------------------------------------------------------------
  logic       hs_want;
  logic       ls_want;
  logic [7:0] dead_r;

  always_comb begin
    hs_want = 1'b0;
    ls_want = 1'b0;
    if (!line_cutoff_i) begin
      unique case (code)
        STAGE_LSON: ls_want = 1'b1;
        STAGE_HSON: hs_want = 1'b1;
        STAGE_PPI: begin
          hs_want = drv_en_i && !tx_i;
          ls_want = drv_en_i && tx_i;
        end
        default: begin
          hs_want = 1'b0;
          ls_want = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_side_switch_o <= 1'b0;
      low_side_switch_o  <= 1'b0;
      dead_r             <= 8'h00;
    end else begin
      high_side_switch_o <= hs_want && !low_side_switch_o && dead_r == 8'h00;
      low_side_switch_o  <= ls_want && !high_side_switch_o && dead_r == 8'h00;
      if ((high_side_switch_o && !hs_want) || (low_side_switch_o && !ls_want)) begin
        dead_r <= 8'(DEAD_CYC);
      end else if (dead_r != 8'h00) begin
        dead_r <= dead_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slow_decay_o <= 1'b0;
    end else begin
      slow_decay_o <= ((code == STAGE_LSON || code == STAGE_HSON || code == STAGE_PPI) && line_cutoff_i) ||
                      (code == STAGE_PPI && (high_side_switch_o || low_side_switch_o) &&
                       !hs_want && !ls_want);
    end
  end

  // ----------------------------------------------------------------
  // Receivers, supply switch and fault request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      receiver_on_o    <= 1'b0;
      rx_o             <= 1'b1;
      aux_rx_on_o      <= 1'b1;
      aux_rx_o         <= 1'b0;
      supply_switch_o  <= 1'b0;
      fast_clamp_o     <= 1'b0;
      fault_req_out_o  <= 1'b0;
      fault_req_oe_n_o <= 1'b1;
      led1_out_o       <= 1'b0;
      led2_out_o       <= 1'b0;
    end else begin
      receiver_on_o    <= !drv_en_i;
      rx_o             <= drv_en_i ? 1'b1 : !line_sense_i;
      aux_rx_on_o      <= 1'b1;
      aux_rx_o         <= aux_in_i;
      supply_switch_o  <= supply_en_i && !supply_cutoff_i;
      fast_clamp_o     <= supply_cutoff_i || (supply_switch_o && !supply_en_i);
      fault_req_out_o  <= 1'b0;
      fault_req_oe_n_o <= (status_r == 8'h00);
      led1_out_o       <= 1'b0;
      led2_out_o       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // LED pattern scanners
  // ----------------------------------------------------------------
  psc_led_if led1_if ();
  psc_led_if led2_if ();
  logic [31:0] step_cnt_r;
  logic        step_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_cnt_r <= 32'h0;
      step_r     <= 1'b0;
    end else begin
      step_r     <= step_cnt_r == 32'(LED_STEP_CYC - 1);
      step_cnt_r <= (step_cnt_r == 32'(LED_STEP_CYC - 1)) ? 32'h0 : step_cnt_r + 32'h1;
    end
  end

  assign led1_if.pattern = {wreg_r[4], wreg_r[5]};
  assign led2_if.pattern = {wreg_r[6], wreg_r[7]};
  assign led1_if.step    = step_r;
  assign led2_if.step    = step_r;

  psc_led_scan u_led1 (.clk_i(clk_i), .reset_n_i(reset_n_i), .led(led1_if.scanner));
  psc_led_scan u_led2 (.clk_i(clk_i), .reset_n_i(reset_n_i), .led(led2_if.scanner));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      led1_oe_n_o <= 1'b1;
      led2_oe_n_o <= 1'b1;
    end else begin
      led1_oe_n_o <= !led1_if.led_on;
      led2_oe_n_o <= !led2_if.led_on;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] ls_off_cnt_r;

  // Cycles since low side was last on, saturating
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ls_off_cnt_r <= 8'hff;
    end else begin
      ls_off_cnt_r <= low_side_switch_o ? 8'h00 : ls_off_cnt_r + 8'(ls_off_cnt_r != 8'hff);
    end
  end

  tristate_off_a: assert property ((code == STAGE_TRI) && $past(code == STAGE_TRI) |->
    !high_side_switch_o && !low_side_switch_o) else $error("switch on in tristate");
  rx_idle_a: assert property ($past(drv_en_i) |-> rx_o && !receiver_on_o)
    else $error("receive output not high while driving");
  rx_invert_a: assert property (!$past(drv_en_i) |-> rx_o == !$past(line_sense_i))
    else $error("receive output not inverted line");
  ls_hold_a: assert property ($rose(code == STAGE_LSON) && !line_cutoff_i |->
    ##[1:40] (low_side_switch_o || line_cutoff_i || code != STAGE_LSON)) else $error("low side not on");
  dead_gap_a: assert property ($rose(high_side_switch_o) |-> ls_off_cnt_r > 8'(DEAD_CYC))
    else $error("high side on inside dead time");
  reject_keep_a: assert property (commit && bad_r |=> code == $past(code) && status_r[STATUS_PE_BIT])
    else $error("forbidden jump not rejected");
  same_ok_a: assert property (wr_stb_i && wr_addr_i == REG_CONFIG &&
    wr_data_i[STAGE_MSB:STAGE_LSB] == code && !bad_r && !commit |=> !bad_r) else $error("rewrite flagged");
  check_calc_a: assert property (commit |=> check_r[6] == ^wreg_r[1] && check_r[0] == ^wreg_r[7])
    else $error("check bit mismatch");
  supply_a: assert property ($past(supply_en_i && !supply_cutoff_i) |-> supply_switch_o)
    else $error("supply switch not on");
  fault_pull_a: assert property (fault_i |=> ##1 !fault_req_oe_n_o)
    else $error("fault request not pulled low");

  reject_c:   cover property (commit && bad_r);
  accept_c:   cover property (commit && !bad_r && stage_v_r[1]);
  led_step_c: cover property (step_r && led1_if.led_on);
  dead_c:     cover property ($fell(low_side_switch_o) ##[1:40] high_side_switch_o);

endmodule : psc_port_stage
`default_nettype wire

// ### psc_host_model.sv
// Host model driving the register port and the line control pins
`timescale 1ns/100ps
`default_nettype none
module psc_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o,
  output logic      [3:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            wr_end_o,
  output logic            rd_stb_o,
  output logic      [3:0] rd_addr_o,
  output logic            drv_en_o,
  output logic            tx_o
);
  import psc_pkg::*;
  initial begin
    {wr_stb_o, wr_end_o, rd_stb_o, drv_en_o, tx_o} = 5'h00;
    {wr_addr_o, rd_addr_o, wr_data_o} = 16'h0000;
  end
  // ---------------------------------------------------------------
  // Transfers, each entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic hold_cycle;
    @(posedge clk_i);
    #1;
  endtask : hold_cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_addr_o = a;
    wr_data_o = d;
    wr_stb_o  = 1'b1;
    hold_cycle();
    wr_stb_o  = 1'b0;
    wr_data_o = ~d;
    hold_cycle();
  endtask : wr
  task automatic commit;
    wr_end_o = 1'b1;
    hold_cycle();
    wr_end_o = 1'b0;
    hold_cycle();
  endtask : commit
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    rd_addr_o = a;
    rd_stb_o  = 1'b1;
    hold_cycle();
    rd_stb_o  = 1'b0;
    d         = rd_data_i;
    hold_cycle();
  endtask : rd
  task automatic stage_to(input logic [2:0] code);
    wr(REG_CONFIG, {STAGE_OFF, 5'h00});
    commit();
    wr(REG_CONFIG, {code, 5'h00});
    commit();
  endtask : stage_to
  task automatic set_line(input logic en, input logic t);
    drv_en_o = en;
    tx_o     = t;
  endtask : set_line
endmodule : psc_host_model
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the port stage block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import psc_pkg::*;
  localparam int STEP = 8;
  localparam int DEAD = 3;
  logic       clk_i, reset_n_i, wr_stb_i, wr_end_i, rd_stb_i, drv_en_i, tx_i;
  logic [3:0] wr_addr_i, rd_addr_i;
  logic [7:0] wr_data_i, rd_data_o, d;
  logic       line_sense_i, line_cutoff_i, supply_en_i, supply_cutoff_i, aux_in_i, fault_i;
  logic       high_side_switch_o, low_side_switch_o, slow_decay_o, receiver_on_o, rx_o;
  logic       supply_switch_o, fast_clamp_o, aux_rx_on_o, aux_rx_o, led1_out_o, led1_oe_n_o;
  logic       led2_out_o, led2_oe_n_o, fault_req_out_o, fault_req_oe_n_o;
  int         failures, checks, n, m;
  wire        led1_line  = led1_oe_n_o ? 1'b1 : led1_out_o;
  wire        led2_line  = led2_oe_n_o ? 1'b1 : led2_out_o;
  wire        fault_line = fault_req_oe_n_o ? 1'b1 : fault_req_out_o;

  psc_port_stage #(.LED_STEP_CYC(STEP), .DEAD_CYC(DEAD)) u_dut (
    .clk_i, .reset_n_i, .wr_stb_i, .wr_addr_i, .wr_data_i, .wr_end_i, .rd_stb_i, .rd_addr_i,
    .rd_data_o, .drv_en_i, .tx_i, .line_sense_i, .line_cutoff_i, .supply_en_i, .supply_cutoff_i,
    .aux_in_i, .fault_i, .high_side_switch_o, .low_side_switch_o, .slow_decay_o, .receiver_on_o,
    .rx_o, .supply_switch_o, .fast_clamp_o, .aux_rx_on_o, .aux_rx_o, .led1_out_o, .led1_oe_n_o,
    .led2_out_o, .led2_oe_n_o, .fault_req_out_o, .fault_req_oe_n_o);
  psc_host_model u_host (
    .clk_i, .rd_data_i(rd_data_o), .wr_stb_o(wr_stb_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i),
    .wr_end_o(wr_end_i), .rd_stb_o(rd_stb_i), .rd_addr_o(rd_addr_i), .drv_en_o(drv_en_i), .tx_o(tx_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic done(input string name);
    $display("test %s finished, %0d failures so far", name, failures);
  endtask : done
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int i = 4; i <= 8; i++) begin
      u_host.rd(4'(i), d);
      cmp(d, 8'h00);
    end
    u_host.rd(REG_CONFIG, d);
    cmp(d, RST_CONFIG);
    done("reset");
  endtask : t_reset
  task automatic t_tristate;
    u_host.set_line(1'b1, 1'b0);
    line_sense_i = 1'b1;
    cyc(2);
    cmp(high_side_switch_o, 1'b0);
    cmp(low_side_switch_o, 1'b0);
    cmp(receiver_on_o, 1'b0);
    cmp(rx_o, 1'b1);
    u_host.set_line(1'b0, 1'b0);
    cyc(2);
    cmp(receiver_on_o, 1'b1);
    cmp(rx_o, 1'b0);
    line_sense_i = 1'b0;
    cyc(2);
    cmp(rx_o, 1'b1);
    done("tristate");
  endtask : t_tristate
  task automatic t_forbidden;
    u_host.wr(REG_CONFIG, {STAGE_LSON, 5'h00});
    u_host.commit();
    cyc(1);
    cmp(low_side_switch_o, 1'b1);
    u_host.set_line(1'b1, 1'b0);
    cyc(2);
    cmp(low_side_switch_o, 1'b1);
    cmp(high_side_switch_o, 1'b0);
    u_host.wr(REG_CONFIG, {STAGE_HSON, 5'h00});
    u_host.commit();
    cyc(1);
    cmp(low_side_switch_o, 1'b1);
    u_host.rd(REG_CONFIG, d);
    cmp(d, {STAGE_LSON, 5'h00});
    u_host.rd(REG_STATUS, d);
    cmp(d[STATUS_PE_BIT], 1'b1);
    done("forbidden jump");
  endtask : t_forbidden
  task automatic t_sequential;
    u_host.wr(REG_L1_HI, 8'h07);
    u_host.wr(REG_L1_LO, 8'h03);
    u_host.wr(REG_CONFIG, {STAGE_LSON, 5'h00});
    u_host.commit();
    cyc(1);
    u_host.rd(REG_STATUS, d);
    cmp(d, 8'h00);
    u_host.rd(REG_L1_HI, d);
    cmp(d, 8'h07);
    u_host.wr(REG_L2_HI, 8'h5a);
    u_host.wr(REG_CONFIG, {STAGE_PPI, 5'h00});
    u_host.wr(REG_L2_LO, 8'h11);
    u_host.commit();
    cyc(1);
    u_host.rd(REG_L2_HI, d);
    cmp(d, 8'h00);
    u_host.rd(REG_L2_LO, d);
    cmp(d, 8'h00);
    u_host.rd(REG_STATUS, d);
    cmp(d[STATUS_PE_BIT], 1'b1);
    u_host.wr(REG_CHECK, 8'hff);
    u_host.wr(REG_L2_HI, 8'h01);
    u_host.wr(REG_L2_LO, 8'h03);
    u_host.commit();
    cyc(1);
    u_host.rd(REG_CHECK, d);
    cmp(d, {^RST_STATUS, ^{STAGE_LSON, 5'h00}, ^RST_CTRL1, ^RST_CTRL2, 4'b1010});
    done("sequential write");
  endtask : t_sequential
  task automatic t_high_side;
    u_host.stage_to(STAGE_HSON);
    cyc(DEAD + 1);
    cmp(high_side_switch_o, 1'b1);
    u_host.set_line(1'b0, 1'b0);
    cyc(2);
    cmp(high_side_switch_o, 1'b1);
    u_host.rd(REG_STATUS, d);
    cmp(d[STATUS_PE_BIT], 1'b0);
    done("high side");
  endtask : t_high_side
  task automatic t_push_pull;
    u_host.stage_to(STAGE_PPI);
    u_host.set_line(1'b1, 1'b0);
    cyc(DEAD + 3);
    cmp(high_side_switch_o, 1'b1);
    cmp(low_side_switch_o, 1'b0);
    u_host.set_line(1'b1, 1'b1);
    cyc(1);
    cmp(high_side_switch_o, 1'b0);
    for (n = 1; low_side_switch_o !== 1'b1; n++) begin
      if (n == 20) begin
        failures++;
        print_verdict();
      end
      cyc(1);
    end
    cmp(8'(n > DEAD), 8'h01);
    u_host.set_line(1'b0, 1'b1);
    cyc(1);
    cmp({high_side_switch_o, low_side_switch_o, slow_decay_o}, 8'h01);
    cyc(1);
    cmp({high_side_switch_o, low_side_switch_o}, 8'h00);
    u_host.set_line(1'b1, 1'b0);
    line_cutoff_i = 1'b1;
    cyc(2);
    cmp({high_side_switch_o, low_side_switch_o, slow_decay_o}, 8'h01);
    line_cutoff_i = 1'b0;
    done("push pull");
  endtask : t_push_pull
  task automatic t_supply;
    supply_en_i = 1'b1;
    cyc(2);
    cmp({supply_switch_o, fast_clamp_o}, 8'h02);
    supply_en_i = 1'b0;
    cyc(1);
    d[0] = fast_clamp_o;
    cyc(1);
    cmp({supply_switch_o, d[0] | fast_clamp_o}, 8'h01);
    supply_en_i     = 1'b1;
    supply_cutoff_i = 1'b1;
    cyc(2);
    cmp({supply_switch_o, fast_clamp_o}, 8'h01);
    supply_cutoff_i = 1'b0;
    aux_in_i        = 1'b1;
    cyc(2);
    cmp({aux_rx_on_o, aux_rx_o}, 8'h03);
    done("supply");
  endtask : t_supply
  task automatic t_led;
    u_host.wr(REG_L1_HI, 8'ha5);
    u_host.wr(REG_L1_LO, 8'hc3);
    u_host.wr(REG_L2_HI, 8'h00);
    u_host.wr(REG_L2_LO, 8'h01);
    u_host.commit();
    cyc(16 * STEP);
    n = 0;
    m = 0;
    repeat (16 * STEP) begin
      cyc(1);
      n += int'(!led1_line);
      m += int'(!led2_line);
    end
    cmp(8'(n), 8'(8 * STEP));
    cmp(8'(m), 8'(STEP));
    done("led scan");
  endtask : t_led
  task automatic t_fault;
    fault_i = 1'b1;
    cyc(1);
    fault_i = 1'b0;
    cyc(2);
    cmp(fault_line, 1'b0);
    u_host.rd(REG_STATUS, d);
    cmp(d[STATUS_OVL_BIT], 1'b1);
    cyc(2);
    cmp(fault_line, 1'b1);
    done("fault");
  endtask : t_fault

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    {line_sense_i, line_cutoff_i, supply_en_i, supply_cutoff_i, aux_in_i, fault_i} = 6'h00;
    failures  = 0;
    checks    = 0;
    reset_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_reset();
    t_tristate();
    t_forbidden();
    t_sequential();
    t_high_side();
    t_push_pull();
    t_supply();
    t_led();
    t_fault();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
